// file: inc/rfdrc_pkg.sv
// package of constants for the rf driver and receive mode control block
// Function
// - ignore-invalid set: drop invalid streams under four bits, receiver stays active.
// - type B framing drops invalid streams only if start-of-frame-required also set.
// - multi-frame bit clear: receiver switches off after one complete frame.
// - multi-frame bit set: receive and transceive keep running after each frame.
// - multi-frame ends on any non-receive command or host clearing the bit.
// - multi-frame: append error register copy to fifo after each stream that is not dropped.
// - framing field selects type A, active, 212/424 passive, or type B.
// - on-inversion bits invert their antenna output while the driver is enabled.
// - off-inversion bits invert their antenna output while the driver is disabled.
// - continuous-carrier bit makes pin b carry unmodulated carrier, else modulated.
// - field check written with enable refuses enables while external field present.
// - carrier enable makes its pin output carrier modulated by transmit data.
// - auto carrier off switches all drivers off after last transmitted bit.
// - force-full-ask applies 100 percent ask regardless of programmed depth.
// - field wakeup: level detector brings device out of soft power-down.
// - collision-avoid enable performs collision avoidance and sets slot value itself.
// - initial collision avoid performs it and clears itself once carrier on; bit 4 is masked off by the auto control mask and reads zero.
// - auto-enable b switches driver b on active delay after field disappears.
// - auto-enable a switches driver a on active delay after field disappears.
// - with initial bit, driver on only if no field during initial delay.
package rfdrc_pkg;
  // register word indices, byte address is four times the index
  localparam logic [7:0] RFDRC_OFF_RX_MODE = 8'h10;
  localparam logic [7:0] RFDRC_OFF_DRV_CTRL = 8'h14;
  localparam logic [7:0] RFDRC_OFF_AUTO_CTRL = 8'h15;
  localparam logic [7:0] RFDRC_OFF_COMMAND = 8'h18;
  localparam logic [7:0] RFDRC_OFF_ERROR = 8'h1c;
  localparam logic [7:0] RFDRC_OFF_STATUS = 8'h20;
  // reset values
  localparam logic [7:0] RFDRC_RST_RX_MODE = 8'h00;
  localparam logic [7:0] RFDRC_RST_DRV_CTRL = 8'h80;
  localparam logic [7:0] RFDRC_RST_AUTO_CTRL = 8'h00;
  // receive mode fields
  localparam int RFDRC_BIT_IGNORE_INVALID = 3;
  localparam int RFDRC_BIT_MULTI_FRAME = 2;
  localparam int RFDRC_BIT_SOF_REQUIRED = 7;
  localparam int RFDRC_BIT_FRAMING_LO = 0;
  // driver control fields
  localparam int RFDRC_BIT_INV_B_ON = 7;
  localparam int RFDRC_BIT_INV_A_ON = 6;
  localparam int RFDRC_BIT_INV_B_OFF = 5;
  localparam int RFDRC_BIT_INV_A_OFF = 4;
  localparam int RFDRC_BIT_CW_B = 3;
  localparam int RFDRC_BIT_FIELD_CHECK = 2;
  localparam int RFDRC_BIT_EN_B = 1;
  localparam int RFDRC_BIT_EN_A = 0;
  // auto control fields
  localparam int RFDRC_BIT_AUTO_OFF = 7;
  localparam int RFDRC_BIT_FULL_ASK = 6;
  localparam int RFDRC_BIT_WAKEUP = 5;
  localparam int RFDRC_BIT_CA_ON = 3;
  localparam int RFDRC_BIT_INITIAL = 2;
  localparam int RFDRC_BIT_AUTO_B = 1;
  localparam int RFDRC_BIT_AUTO_A = 0;
  localparam logic [7:0] RFDRC_AUTO_MASK = 8'hef;
  localparam int RFDRC_SHORT_BITS = 4;
  // commands
  localparam logic [3:0] RFDRC_CMD_IDLE = 4'h0;
  localparam logic [3:0] RFDRC_CMD_TRANSMIT = 4'h4;
  localparam logic [3:0] RFDRC_CMD_RECEIVE = 4'h8;
  localparam logic [3:0] RFDRC_CMD_TRANSCEIVE = 4'hc;
  // framing codes
  localparam logic [1:0] RFDRC_FRM_TYPE_A = 2'h0;
  localparam logic [1:0] RFDRC_FRM_ACTIVE = 2'h1;
  localparam logic [1:0] RFDRC_FRM_PASSIVE_HI = 2'h2;
  localparam logic [1:0] RFDRC_FRM_TYPE_B = 2'h3;
  // timing
  localparam int RFDRC_CLK_HZ = 10000000;
  localparam int RFDRC_ACTIVE_DELAY_US = 100;
  localparam int RFDRC_INITIAL_DELAY_US = 410;
  localparam int RFDRC_ACTIVE_DELAY_CYC = RFDRC_ACTIVE_DELAY_US * (RFDRC_CLK_HZ / 1000000);
  localparam int RFDRC_INITIAL_DELAY_CYC = RFDRC_INITIAL_DELAY_US * (RFDRC_CLK_HZ / 1000000);
  localparam logic [1:0] RFDRC_RESP_OKAY = 2'h0;
  localparam logic [1:0] RFDRC_RESP_SLVERR = 2'h2;
endpackage : rfdrc_pkg

// file: core/rfdrc_top.sv
// rf driver control and receive mode control with axi4-lite registers
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rfdrc_top #(
  parameter int ACTIVE_DELAY_CYC = rfdrc_pkg::RFDRC_ACTIVE_DELAY_CYC,
  parameter int INITIAL_DELAY_CYC = rfdrc_pkg::RFDRC_INITIAL_DELAY_CYC,
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic carrier_clk,
  input wire logic tx_mod_data,
  input wire logic tx_last_bit,
  input wire logic external_field,
  input wire logic rx_stream_end,
  input wire logic rx_stream_invalid,
  input wire logic [7:0] rx_stream_bits,
  input wire logic rx_sof_seen,
  input wire logic soft_power_down,
  output logic antenna_out_a,
  output logic antenna_out_b,
  output logic full_ask,
  output logic wakeup,
  output logic collision_avoid,
  output logic receiver_on,
  output logic [1:0] receive_framing_select,
  output logic fifo_push,
  output logic [7:0] fifo_data
);
  import rfdrc_pkg::*;

  typedef enum logic [1:0] {
    RFDRC_AUTO_IDLE = 2'b00,
    RFDRC_AUTO_WAIT_ACTIVE = 2'b01,
    RFDRC_AUTO_WAIT_INITIAL = 2'b10
  } rfdrc_auto_e;

  // **********************************************************
  // registers
  // **********************************************************
  logic [7:0] receive_mode_control_reg;
  logic [7:0] antenna_driver_control_reg;
  logic [7:0] antenna_auto_control_reg;
  logic [3:0] command_register_reg;
  logic [7:0] error_register_reg;
  rfdrc_auto_e auto_state_reg;
  logic [CNT_W-1:0] delay_cnt_reg;
  logic field_prev_reg;

  // **********************************************************
  // axi4-lite slave
  // **********************************************************
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;
  logic wr_fire;
  logic wr_hit;
  logic [7:0] wbyte;

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wbyte = wdata_reg[7:0];
  always_comb begin
    if (awaddr_reg == RFDRC_OFF_RX_MODE) begin
      wr_hit = 1'b1;
    end else if (awaddr_reg == RFDRC_OFF_DRV_CTRL) begin
      wr_hit = 1'b1;
    end else if (awaddr_reg == RFDRC_OFF_AUTO_CTRL) begin
      wr_hit = 1'b1;
    end else if (awaddr_reg == RFDRC_OFF_COMMAND) begin
      wr_hit = 1'b1;
    end else if (awaddr_reg == RFDRC_OFF_ERROR) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RFDRC_RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= {2'b00, s_axi_awaddr[7:2]};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RFDRC_RESP_OKAY : RFDRC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_en;
  assign wr_en = wr_fire && wstrb0_reg;

  logic [7:0] rd_mux;
  logic rd_hit;
  logic [7:0] rd_idx;
  assign rd_idx = {2'b00, s_axi_araddr[7:2]};
  always_comb begin
    rd_hit = 1'b1;
    if (rd_idx == RFDRC_OFF_RX_MODE) begin
      rd_mux = receive_mode_control_reg;
    end else if (rd_idx == RFDRC_OFF_DRV_CTRL) begin
      // field check bit is write only
      rd_mux = antenna_driver_control_reg & ~(8'h01 << RFDRC_BIT_FIELD_CHECK);
    end else if (rd_idx == RFDRC_OFF_AUTO_CTRL) begin
      rd_mux = antenna_auto_control_reg;
    end else if (rd_idx == RFDRC_OFF_COMMAND) begin
      rd_mux = {4'h0, command_register_reg};
    end else if (rd_idx == RFDRC_OFF_ERROR) begin
      rd_mux = error_register_reg;
    end else if (rd_idx == RFDRC_OFF_STATUS) begin
      rd_mux = {3'h0, external_field, receiver_on, auto_state_reg, antenna_out_a};
    end else begin
      rd_mux = 8'h00;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RFDRC_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_mux};
        s_axi_rresp <= rd_hit ? RFDRC_RESP_OKAY : RFDRC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // **********************************************************
  // receive mode and command
  // **********************************************************
  logic multi;
  logic short_invalid;
  logic discard;
  logic cmd_is_rx;
  assign multi = receive_mode_control_reg[RFDRC_BIT_MULTI_FRAME];
  assign cmd_is_rx = (command_register_reg == RFDRC_CMD_RECEIVE) ||
                     (command_register_reg == RFDRC_CMD_TRANSCEIVE);
  assign short_invalid = rx_stream_invalid && (rx_stream_bits < 8'(RFDRC_SHORT_BITS));
  always_comb begin
    discard = receive_mode_control_reg[RFDRC_BIT_IGNORE_INVALID] && short_invalid;
    if (receive_mode_control_reg[1:0] == RFDRC_FRM_TYPE_B) begin
      discard = discard && receive_mode_control_reg[RFDRC_BIT_SOF_REQUIRED];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      receive_mode_control_reg <= RFDRC_RST_RX_MODE;
    end else if (ce && wr_en && awaddr_reg == RFDRC_OFF_RX_MODE) begin
      receive_mode_control_reg <= wbyte; // host clearing multi bit stops reception after the next frame
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      command_register_reg <= RFDRC_CMD_IDLE;
    end else if (ce) begin
      if (wr_en && awaddr_reg == RFDRC_OFF_COMMAND) begin
        command_register_reg <= wbyte[3:0];
      end else if (cmd_is_rx && rx_stream_end && !discard && !multi) begin
        command_register_reg <= RFDRC_CMD_IDLE;
      end else if (command_register_reg == RFDRC_CMD_TRANSMIT && tx_last_bit) begin
        command_register_reg <= RFDRC_CMD_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      error_register_reg <= 8'h00;
    end else if (ce) begin
      if (wr_en && awaddr_reg == RFDRC_OFF_ERROR) begin
        error_register_reg <= wbyte;
      end
      if (cmd_is_rx && rx_stream_end && rx_stream_invalid && !discard) begin
        error_register_reg[0] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      receiver_on <= 1'b0;
      fifo_push <= 1'b0;
      fifo_data <= 8'h00;
      receive_framing_select <= RFDRC_FRM_TYPE_A;
    end else if (ce) begin
      receive_framing_select <= receive_mode_control_reg[1:0];
      receiver_on <= cmd_is_rx && !(rx_stream_end && !discard && !multi);
      fifo_push <= cmd_is_rx && multi && rx_stream_end && !discard;
      fifo_data <= error_register_reg;
    end
  end

  // **********************************************************
  // antenna driver control
  // **********************************************************
  logic [7:0] drv_wr;
  logic field_fall;
  logic auto_fire;
  assign field_fall = field_prev_reg && !external_field;
  always_comb begin
    drv_wr = wbyte;
    if (wbyte[RFDRC_BIT_FIELD_CHECK] && external_field) begin
      drv_wr[RFDRC_BIT_EN_B] = antenna_driver_control_reg[RFDRC_BIT_EN_B];
      drv_wr[RFDRC_BIT_EN_A] = antenna_driver_control_reg[RFDRC_BIT_EN_A];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      antenna_driver_control_reg <= RFDRC_RST_DRV_CTRL;
    end else if (ce) begin
      if (wr_en && awaddr_reg == RFDRC_OFF_DRV_CTRL) begin
        antenna_driver_control_reg <= drv_wr;
      end else if (auto_fire) begin
        antenna_driver_control_reg[RFDRC_BIT_EN_B] <= 
          antenna_driver_control_reg[RFDRC_BIT_EN_B] |
          antenna_auto_control_reg[RFDRC_BIT_AUTO_B];
        antenna_driver_control_reg[RFDRC_BIT_EN_A] <= 
          antenna_driver_control_reg[RFDRC_BIT_EN_A] |
          antenna_auto_control_reg[RFDRC_BIT_AUTO_A];
      end else if (antenna_auto_control_reg[RFDRC_BIT_AUTO_OFF] && tx_last_bit) begin
        antenna_driver_control_reg[RFDRC_BIT_EN_B] <= 1'b0;
        antenna_driver_control_reg[RFDRC_BIT_EN_A] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      antenna_auto_control_reg <= RFDRC_RST_AUTO_CTRL;
    end else if (ce) begin
      if (wr_en && awaddr_reg == RFDRC_OFF_AUTO_CTRL) begin
        antenna_auto_control_reg <= wbyte & RFDRC_AUTO_MASK;
      end else if (auto_fire && auto_state_reg == RFDRC_AUTO_WAIT_INITIAL) begin
        antenna_auto_control_reg[RFDRC_BIT_INITIAL] <= 1'b0;
      end
    end
  end

  // auto switch-on sequencer
  logic auto_any;
  assign auto_any = antenna_auto_control_reg[RFDRC_BIT_AUTO_B] |
                    antenna_auto_control_reg[RFDRC_BIT_AUTO_A];
  assign auto_fire = (auto_state_reg != RFDRC_AUTO_IDLE) && delay_cnt_reg == '0 &&
                     !external_field;

  always_ff @(posedge clk) begin
    if (rst) begin
      field_prev_reg <= 1'b0;
    end else if (ce) begin
      field_prev_reg <= external_field;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      auto_state_reg <= RFDRC_AUTO_IDLE;
      delay_cnt_reg <= '0;
    end else if (ce) begin
      case (auto_state_reg)
        RFDRC_AUTO_IDLE: begin
          if (auto_any && antenna_auto_control_reg[RFDRC_BIT_INITIAL] && !external_field) begin
            auto_state_reg <= RFDRC_AUTO_WAIT_INITIAL;
            delay_cnt_reg <= CNT_W'(INITIAL_DELAY_CYC - 1);
          end else if (auto_any && field_fall) begin
            auto_state_reg <= RFDRC_AUTO_WAIT_ACTIVE;
            delay_cnt_reg <= CNT_W'(ACTIVE_DELAY_CYC - 1);
          end
        end
        RFDRC_AUTO_WAIT_ACTIVE, RFDRC_AUTO_WAIT_INITIAL: begin
          if (external_field || !auto_any) begin
            auto_state_reg <= RFDRC_AUTO_IDLE;
          end else if (delay_cnt_reg == '0) begin
            auto_state_reg <= RFDRC_AUTO_IDLE;
          end else begin
            delay_cnt_reg <= delay_cnt_reg - 1'b1;
          end
        end
        default: begin
          auto_state_reg <= RFDRC_AUTO_IDLE;
        end
      endcase
    end
  end

  // **********************************************************
  // antenna outputs
  // **********************************************************
  logic en_a;
  logic en_b;
  logic mod_b;
  assign en_a = antenna_driver_control_reg[RFDRC_BIT_EN_A];
  assign en_b = antenna_driver_control_reg[RFDRC_BIT_EN_B];
  assign mod_b = antenna_driver_control_reg[RFDRC_BIT_CW_B] ? carrier_clk :
                 (carrier_clk & tx_mod_data);

  always_ff @(posedge clk) begin
    if (rst) begin
      antenna_out_a <= 1'b0;
      antenna_out_b <= 1'b0;
      full_ask <= 1'b0;
      wakeup <= 1'b0;
      collision_avoid <= 1'b0;
    end else if (ce) begin
      antenna_out_a <= en_a ?
        ((carrier_clk & tx_mod_data) ^ antenna_driver_control_reg[RFDRC_BIT_INV_A_ON]) :
        antenna_driver_control_reg[RFDRC_BIT_INV_A_OFF];
      antenna_out_b <= en_b ? (mod_b ^ antenna_driver_control_reg[RFDRC_BIT_INV_B_ON]) :
        antenna_driver_control_reg[RFDRC_BIT_INV_B_OFF];
      full_ask <= antenna_auto_control_reg[RFDRC_BIT_FULL_ASK];
      wakeup <= antenna_auto_control_reg[RFDRC_BIT_WAKEUP] && soft_power_down &&
                external_field;
      collision_avoid <= antenna_auto_control_reg[RFDRC_BIT_CA_ON];
    end
  end
endmodule : rfdrc_top
`default_nettype wire

// file: test/rfdrc_chk.sv
// checker of bus, wakeup and fifo push timing
`timescale 1ns/10ps
`default_nettype none
module rfdrc_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_stream_end,
  input wire logic external_field,
  input wire logic soft_power_down,
  input wire logic wakeup,
  input wire logic fifo_push
);
  // ****************
  // bus and event checks
  // ****************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence w_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_answer;
    ##[1:2] s_axi_bvalid;
  endsequence
  a_push_pulse: assert property (fifo_push |=> !fifo_push)
    else $error("fifo push longer than one cycle");
  a_push_cause: assert property (fifo_push |-> $past(rx_stream_end))
    else $error("fifo push without stream end");
  a_wake_cause: assert property (wakeup |-> $past(soft_power_down) && $past(external_field))
    else $error("wakeup without field in power down");
  a_write_answer: assert property (w_taken |-> b_answer)
    else $error("write response late");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid)
    else $error("read response late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read upper bits not zero");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
endmodule : rfdrc_chk
`default_nettype wire

// file: test/rfdrc_field_model.sv
// far side model: external field, carrier level, transmit data
`timescale 1ns/10ps
`default_nettype none
module rfdrc_field_model (
  input wire logic clk,
  input wire logic field_req,
  input wire logic carrier_req,
  input wire logic data_req,
  input wire logic last_req,
  output logic external_field = 1'b0,
  output logic carrier_clk = 1'b0,
  output logic tx_mod_data = 1'b0,
  output logic tx_last_bit = 1'b0
);
  logic last_dly_reg = 1'b0;
  // last bit is a one-cycle pulse on request
  always @(posedge clk) begin
    external_field <= field_req;
    carrier_clk <= carrier_req;
    tx_mod_data <= data_req;
    last_dly_reg <= last_req;
    tx_last_bit <= last_req & ~last_dly_reg;
  end
endmodule : rfdrc_field_model
`default_nettype wire

// file: test/testbench.sv
// register level testbench of the rf driver and receive mode block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import rfdrc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, spd = 1'b0;
  logic fld = 1'b0, car = 1'b0, dat = 1'b0, lst = 1'b0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0] awa = 8'h0, ara = 8'h0, bits = 8'h0;
  logic [31:0] wd = 32'h0;
  logic se = 1'b0, sinv = 1'b0;
  wire logic awr, wr_rdy, bv, arr, rv, ef, cc, md, lb, oa, ob, fa, wk, ca, ron, fp;
  wire logic [1:0] brs, rrs, fsel;
  wire logic [31:0] rdt;
  wire logic [7:0] fdat;
  int err_total = 0, checks_done = 0, pushes = 0, n0;
  always #50 clk = ~clk;
  always @(posedge clk) if (fp === 1'b1) pushes++;
  rfdrc_top #(.ACTIVE_DELAY_CYC(20), .INITIAL_DELAY_CYC(30)) u_rfdrc_top (
    .clk(clk), .rst(rst), .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rr), .carrier_clk(cc),
    .tx_mod_data(md), .tx_last_bit(lb), .external_field(ef), .rx_stream_end(se),
    .rx_stream_invalid(sinv), .rx_stream_bits(bits), .rx_sof_seen(1'b0),
    .soft_power_down(spd), .antenna_out_a(oa), .antenna_out_b(ob), .full_ask(fa),
    .wakeup(wk), .collision_avoid(ca), .receiver_on(ron), .receive_framing_select(fsel),
    .fifo_push(fp), .fifo_data(fdat));
  rfdrc_field_model u_rfdrc_field_model (.clk(clk), .field_req(fld), .carrier_req(car),
    .data_req(dat), .last_req(lst), .external_field(ef), .carrier_clk(cc),
    .tx_mod_data(md), .tx_last_bit(lb));
  // ****************
  // tasks
  // ****************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awa <= {a[5:0], 2'b00};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awv && awr) begin
        aw_ok = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wr_rdy) begin
        w_ok = 1'b1;
        wv <= 1'b0;
      end
    end
    repeat (2) @(posedge clk);
    br <= 1'b1;
    do @(posedge clk); while (bv !== 1'b1);
    br <= 1'b0;
    chk({30'h0, brs}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    ara <= {a[5:0], 2'b00};
    arv <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    repeat (2) @(posedge clk);
    rr <= 1'b1;
    do @(posedge clk); while (rv !== 1'b1);
    rr <= 1'b0;
    chk({30'h0, rrs}, {30'h0, er});
    chk(rdt, {24'h0, exp});
  endtask : rd
  task automatic strm(input logic inv, input logic [7:0] n);
    se <= 1'b1;
    sinv <= inv;
    bits <= n;
    @(posedge clk);
    se <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : strm
  task automatic pins(input logic [1:0] exp);
    repeat (4) @(posedge clk);
    chk({30'h0, ob, oa}, {30'h0, exp});
  endtask : pins
  // ****************
  // tests
  // ****************
  initial begin
    repeat (8000) @(posedge clk);
    err_total++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(RFDRC_OFF_DRV_CTRL, 8'h80, RFDRC_RESP_OKAY);
    rd(RFDRC_OFF_AUTO_CTRL, 8'h00, RFDRC_RESP_OKAY);
    rd(RFDRC_OFF_RX_MODE, 8'h00, RFDRC_RESP_OKAY);
    rd(8'h3f, 8'h00, RFDRC_RESP_SLVERR);
    wr(8'h3f, 8'hff, RFDRC_RESP_SLVERR);
    wr(RFDRC_OFF_AUTO_CTRL, 8'hf8, RFDRC_RESP_OKAY);
    rd(RFDRC_OFF_AUTO_CTRL, 8'he8, RFDRC_RESP_OKAY);
    chk({30'h0, fa, ca}, 32'h3);
    spd <= 1'b1;
    fld <= 1'b1;
    pins(2'h0);
    chk({31'h0, wk}, 32'h1);
    spd <= 1'b0;
    fld <= 1'b0;
    wr(RFDRC_OFF_AUTO_CTRL, 8'h00, RFDRC_RESP_OKAY);
    chk({30'h0, fa, wk}, 32'h0);
    $display("auto control test done");
    wr(RFDRC_OFF_DRV_CTRL, 8'h30, RFDRC_RESP_OKAY);
    pins(2'h3);
    car <= 1'b1;
    dat <= 1'b1;
    wr(RFDRC_OFF_DRV_CTRL, 8'h03, RFDRC_RESP_OKAY);
    pins(2'h3);
    dat <= 1'b0;
    pins(2'h0);
    wr(RFDRC_OFF_DRV_CTRL, 8'h0b, RFDRC_RESP_OKAY);
    pins(2'h2);
    wr(RFDRC_OFF_DRV_CTRL, 8'hc3, RFDRC_RESP_OKAY);
    pins(2'h3);
    wr(RFDRC_OFF_DRV_CTRL, 8'h00, RFDRC_RESP_OKAY);
    fld <= 1'b1;
    wr(RFDRC_OFF_DRV_CTRL, 8'h07, RFDRC_RESP_OKAY);
    rd(RFDRC_OFF_DRV_CTRL, 8'h00, RFDRC_RESP_OKAY);
    wr(RFDRC_OFF_DRV_CTRL, 8'h03, RFDRC_RESP_OKAY);
    rd(RFDRC_OFF_DRV_CTRL, 8'h03, RFDRC_RESP_OKAY);
    fld <= 1'b0;
    wr(RFDRC_OFF_AUTO_CTRL, 8'h80, RFDRC_RESP_OKAY);
    wr(RFDRC_OFF_COMMAND, {4'h0, RFDRC_CMD_TRANSMIT}, RFDRC_RESP_OKAY);
    lst <= 1'b1;
    pins(2'h0);
    lst <= 1'b0;
    rd(RFDRC_OFF_DRV_CTRL, 8'h00, RFDRC_RESP_OKAY);
    $display("driver test done");
    fld <= 1'b1;
    wr(RFDRC_OFF_AUTO_CTRL, 8'h03, RFDRC_RESP_OKAY);
    fld <= 1'b0;
    rd(RFDRC_OFF_DRV_CTRL, 8'h00, RFDRC_RESP_OKAY);
    repeat (30) @(posedge clk);
    rd(RFDRC_OFF_DRV_CTRL, 8'h03, RFDRC_RESP_OKAY);
    wr(RFDRC_OFF_DRV_CTRL, 8'h00, RFDRC_RESP_OKAY);
    wr(RFDRC_OFF_AUTO_CTRL, 8'h06, RFDRC_RESP_OKAY);
    rd(RFDRC_OFF_AUTO_CTRL, 8'h06, RFDRC_RESP_OKAY);
    repeat (40) @(posedge clk);
    rd(RFDRC_OFF_AUTO_CTRL, 8'h02, RFDRC_RESP_OKAY);
    rd(RFDRC_OFF_DRV_CTRL, 8'h02, RFDRC_RESP_OKAY);
    wr(RFDRC_OFF_AUTO_CTRL, 8'h00, RFDRC_RESP_OKAY);
    $display("auto enable test done");
    wr(RFDRC_OFF_ERROR, 8'h5a, RFDRC_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(RFDRC_OFF_RX_MODE, 8'(i), RFDRC_RESP_OKAY);
      chk({30'h0, fsel}, 32'(i));
    end
    wr(RFDRC_OFF_RX_MODE, 8'h0c, RFDRC_RESP_OKAY);
    wr(RFDRC_OFF_COMMAND, {4'h0, RFDRC_CMD_RECEIVE}, RFDRC_RESP_OKAY);
    n0 = pushes;
    strm(1'b0, 8'h08);
    chk(32'(pushes), 32'(n0 + 1));
    chk({24'h0, fdat}, 32'h5a);
    chk({31'h0, ron}, 32'h1);
    strm(1'b1, 8'h03);
    chk(32'(pushes), 32'(n0 + 1));
    chk({31'h0, ron}, 32'h1);
    wr(RFDRC_OFF_RX_MODE, 8'h0f, RFDRC_RESP_OKAY);
    strm(1'b1, 8'h03);
    chk(32'(pushes), 32'(n0 + 2));
    wr(RFDRC_OFF_RX_MODE, 8'h8f, RFDRC_RESP_OKAY);
    strm(1'b1, 8'h03);
    chk(32'(pushes), 32'(n0 + 2));
    wr(RFDRC_OFF_COMMAND, {4'h0, RFDRC_CMD_IDLE}, RFDRC_RESP_OKAY);
    chk({31'h0, ron}, 32'h0);
    wr(RFDRC_OFF_RX_MODE, 8'h00, RFDRC_RESP_OKAY);
    wr(RFDRC_OFF_COMMAND, {4'h0, RFDRC_CMD_TRANSCEIVE}, RFDRC_RESP_OKAY);
    chk({31'h0, ron}, 32'h1);
    strm(1'b0, 8'h08);
    chk({31'h0, ron}, 32'h0);
    $display("receive test done");
    finish_test();
  end
endmodule : testbench
bind rfdrc_top rfdrc_chk u_rfdrc_chk (.clk(clk), .rst(rst), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .rx_stream_end(rx_stream_end), .external_field(external_field),
  .soft_power_down(soft_power_down), .wakeup(wakeup), .fifo_push(fifo_push));
`default_nettype wire
